// File: src/erc_pkg.sv
// Contract
// - When a message is passed to its receiver, the destination token is replaced by the sender's node identifier.
// - Each two-way switch port carries two logical channels, one in each direction, between a node and the crossbar.
// - The controller reads one token byte from the chain, takes one of three paths by its value, and then waits for the next token.
// - For a token that is neither a request nor a release, the controller reads and discards the next two bytes.
// - On a route request token, the controller reads two more bytes: the source node, then the destination node.
// - For a request, the controller sends a query command and the source identifier to the switch and takes the peer byte, then does the same for the destination.
// - A returned peer byte becomes the nil node value when the switch reports that output as inactive, and is otherwise kept.
// - After both queries, the controller sends release token, source peer, destination peer, source, destination onto the outgoing chain.
// - Switch commands are: one-way route 0, pair connect 1, query 2, settle 3, clear 4, drop output 5, unpair 6.
// - Every output, input or port identifier sent after a command byte lies in the range 0 to 31.
// - The switch answers a query with the connected input identifier, and bit 7 is set when that output is inactive.
// - The inactive test masks the peer byte with 80 hex and treats the output as inactive when that bit is set.
package erc_pkg;
	localparam logic [7:0] ROUTE_ONE_WAY_CMD   = 8'h00;
	localparam logic [7:0] PAIR_CONNECT_CMD    = 8'h01;
	localparam logic [7:0] QUERY_PEER_CMD      = 8'h02;
	localparam logic [7:0] SETTLE_CMD          = 8'h03;
	localparam logic [7:0] SWITCH_CLEAR_CMD    = 8'h04;
	localparam logic [7:0] DROP_OUTPUT_CMD     = 8'h05;
	localparam logic [7:0] UNPAIR_CMD          = 8'h06;
	localparam logic [7:0] ROUTE_REQUEST_TOKEN = 8'h10;
	localparam logic [7:0] RELEASE_TOKEN       = 8'h11;
	localparam logic [7:0] ROUTE_ACK_TOKEN     = 8'h12;
	localparam logic [7:0] NIL_NODE            = 8'hFF;
	localparam logic [7:0] ACTIVE_MASK         = 8'h80;
	localparam logic [7:0] PORT_ID_MASK        = 8'h1F;
	localparam logic [2:0] REL_LEN             = 3'h5;

	typedef enum logic [3:0] {
		ERC_IDLE,
		ERC_SKIP,
		ERC_REQ_SRC,
		ERC_REQ_DST,
		ERC_Q_CMD,
		ERC_Q_ID,
		ERC_Q_ANS,
		ERC_EMIT,
		ERC_REL_PASS
	} erc_state_e;
endpackage

// File: src/erc_byte_out.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// registered byte output stage
// ----------------------------------------
module erc_byte_out
	import erc_pkg::*;
(
	input  wire logic       ref_clk, // clock
	input  wire logic       rst_n,   // async reset
	input  wire logic       load,    // take new byte
	input  wire logic [7:0] din,     // byte to send
	input  wire logic       ready,   // far side accepts
	output logic            valid,   // byte offered
	output logic      [7:0] dout     // byte
);
	logic       next_valid;
	logic [7:0] next_dout;

	always_comb begin
		next_valid = valid;
		next_dout  = dout;
		if (valid && ready) begin
			next_valid = 1'b0;
		end
		if (load) begin
			next_valid = 1'b1;
			next_dout  = din;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
			dout  <= 8'h00;
		end else begin
			valid <= next_valid;
			dout  <= next_dout;
		end
	end
endmodule
`default_nettype wire

// File: src/erc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module exchange_route_controller
	import erc_pkg::*;
(
	input  wire logic       ref_clk,      // 100 MHz clock
	input  wire logic       rst_n,        // async reset, active low
	input  wire logic       chain_valid,  // incoming chain byte offered
	input  wire logic [7:0] chain_data,   // incoming chain byte
	output logic            chain_ready,  // incoming byte taken
	output logic            up_valid,     // outgoing chain byte offered
	output logic      [7:0] up_data,      // outgoing chain byte
	input  wire logic       up_ready,     // outgoing byte accepted
	output logic            cfg_valid,    // switch command byte offered
	output logic      [7:0] cfg_data,     // switch command byte
	input  wire logic       cfg_ready,    // switch took command byte
	input  wire logic       ans_valid,    // switch answer offered
	input  wire logic [7:0] ans_data,     // switch answer byte
	output logic            ans_ready,    // answer taken
	output logic            busy          // token in progress
);
	erc_state_e state, next_state;
	logic [7:0] src, next_src;
	logic [7:0] dst, next_dst;
	logic [7:0] src_peer, next_src_peer;
	logic [7:0] dst_peer, next_dst_peer;
	logic       q_dst, next_q_dst;
	logic [2:0] cnt, next_cnt;
	logic       next_chain_ready;
	logic       next_ans_ready;
	logic       next_busy;
	logic       up_load, cfg_load;
	logic [7:0] up_din, cfg_din;
	logic [7:0] peer_fixed;
	logic       chain_take, ans_take;

	assign chain_take = chain_valid && chain_ready;
	assign ans_take   = ans_valid && ans_ready;

	// ----------------------------------------
	// peer clean-up
	// ----------------------------------------
	always_comb begin
		peer_fixed = ans_data;
		if ((ans_data & ACTIVE_MASK) == ACTIVE_MASK) begin
			peer_fixed = NIL_NODE;
		end
	end

	// ----------------------------------------
	// token sequencer
	// ----------------------------------------
	always_comb begin
		next_state       = state;
		next_src         = src;
		next_dst         = dst;
		next_src_peer    = src_peer;
		next_dst_peer    = dst_peer;
		next_q_dst       = q_dst;
		next_cnt         = cnt;
		next_chain_ready = 1'b0;
		next_ans_ready   = 1'b0;
		up_load          = 1'b0;
		up_din           = 8'h00;
		cfg_load         = 1'b0;
		cfg_din          = 8'h00;
		case (state)
			ERC_IDLE: begin
				next_chain_ready = !chain_take;
				if (chain_take) begin
					next_cnt = 3'h0;
					if (chain_data == ROUTE_REQUEST_TOKEN) begin
						next_state       = ERC_REQ_SRC;
						next_chain_ready = 1'b1;
					end else if (chain_data == RELEASE_TOKEN) begin
						next_state = ERC_REL_PASS;
					end else begin
						next_state       = ERC_SKIP;
						next_chain_ready = 1'b1;
					end
				end
			end
			ERC_SKIP: begin
				next_chain_ready = 1'b1;
				if (chain_take) begin
					next_cnt = cnt + 3'h1;
					if (cnt == 3'h1) begin
						next_chain_ready = 1'b0;
						next_state       = ERC_IDLE;
					end
				end
			end
			ERC_REQ_SRC: begin
				next_chain_ready = 1'b1;
				if (chain_take) begin
					next_src   = chain_data;
					next_state = ERC_REQ_DST;
				end
			end
			ERC_REQ_DST: begin
				next_chain_ready = !chain_take;
				if (chain_take) begin
					next_dst   = chain_data;
					next_q_dst = 1'b0;
					next_state = ERC_Q_CMD;
				end
			end
			ERC_Q_CMD: begin
				if (!cfg_valid) begin
					cfg_load   = 1'b1;
					cfg_din    = QUERY_PEER_CMD;
					next_state = ERC_Q_ID;
				end
			end
			ERC_Q_ID: begin
				if (!cfg_valid || cfg_ready) begin
					cfg_load       = 1'b1;
					cfg_din        = (q_dst ? dst : src) & PORT_ID_MASK;
					next_state     = ERC_Q_ANS;
					next_ans_ready = 1'b1;
				end
			end
			ERC_Q_ANS: begin
				next_ans_ready = 1'b1;
				if (ans_take) begin
					next_ans_ready = 1'b0;
					if (q_dst) begin
						next_dst_peer = peer_fixed;
						next_cnt      = 3'h0;
						next_state    = ERC_EMIT;
					end else begin
						next_src_peer = peer_fixed;
						next_q_dst    = 1'b1;
						next_state    = ERC_Q_CMD;
					end
				end
			end
			ERC_EMIT: begin
				if (!up_valid || up_ready) begin
					up_load  = 1'b1;
					next_cnt = cnt + 3'h1;
					case (cnt)
						3'h0: up_din = RELEASE_TOKEN;
						3'h1: up_din = src_peer;
						3'h2: up_din = dst_peer;
						3'h3: up_din = src;
						default: up_din = dst;
					endcase
					if (cnt == REL_LEN - 3'h1) begin
						next_state = ERC_IDLE;
					end
				end
			end
			ERC_REL_PASS: begin
				// release handling lies outside this block; forward it unchanged
				if (cnt == 3'h0) begin
					if (!up_valid || up_ready) begin
						up_load          = 1'b1;
						up_din           = RELEASE_TOKEN;
						next_cnt         = 3'h1;
					end
				end else begin
					next_chain_ready = !chain_take && (!up_valid || up_ready);
					if (chain_take) begin
						up_load  = 1'b1;
						up_din   = chain_data;
						next_cnt = cnt + 3'h1;
						if (cnt == REL_LEN - 3'h1) begin
							next_chain_ready = 1'b0;
							next_state       = ERC_IDLE;
						end
					end
				end
			end
			default: next_state = ERC_IDLE;
		endcase
		next_busy = (next_state != ERC_IDLE);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= ERC_IDLE;
			src         <= 8'h00;
			dst         <= 8'h00;
			src_peer    <= 8'h00;
			dst_peer    <= 8'h00;
			q_dst       <= 1'b0;
			cnt         <= 3'h0;
			chain_ready <= 1'b0;
			ans_ready   <= 1'b0;
			busy        <= 1'b0;
		end else begin
			state       <= next_state;
			src         <= next_src;
			dst         <= next_dst;
			src_peer    <= next_src_peer;
			dst_peer    <= next_dst_peer;
			q_dst       <= next_q_dst;
			cnt         <= next_cnt;
			chain_ready <= next_chain_ready;
			ans_ready   <= next_ans_ready;
			busy        <= next_busy;
		end
	end

	// ----------------------------------------
	// output byte stages
	// ----------------------------------------
	erc_byte_out u_up (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.load    (up_load),
		.din     (up_din),
		.ready   (up_ready),
		.valid   (up_valid),
		.dout    (up_data)
	);

	erc_byte_out u_cfg (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.load    (cfg_load),
		.din     (cfg_din),
		.ready   (cfg_ready),
		.valid   (cfg_valid),
		.dout    (cfg_data)
	);
endmodule
`default_nettype wire

// File: verification/erc_ctl_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// port checks
// ---------------
module erc_ctl_chk
	import erc_pkg::*;
(
	input wire logic       ref_clk,     // clk
	input wire logic       rst_n,       // rst
	input wire logic       chain_valid, // in
	input wire logic [7:0] chain_data,  // in
	input wire logic       chain_ready, // out
	input wire logic       up_valid,    // out
	input wire logic [7:0] up_data,     // out
	input wire logic       up_ready,    // in
	input wire logic       cfg_valid,   // out
	input wire logic [7:0] cfg_data,    // out
	input wire logic       cfg_ready,   // in
	input wire logic       ans_valid,   // in
	input wire logic [7:0] ans_data,    // in
	input wire logic       ans_ready,   // out
	input wire logic       busy         // out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic take = chain_valid && chain_ready;
	property p_quiet; $rose(rst_n) |-> !(chain_ready || up_valid || cfg_valid || busy); endproperty
	a_quiet: assert property (p_quiet) else $error("outputs after reset");
	property p_up_hold; up_valid && !up_ready |=> up_valid && $stable(up_data); endproperty
	a_up_hold: assert property (p_up_hold) else $error("up byte dropped");
	property p_cfg_hold; cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data); endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("cfg byte dropped");
	property p_refuse; cfg_valid || ans_ready |-> !chain_ready; endproperty
	a_refuse: assert property (p_refuse) else $error("byte taken in query");
	property p_cmd; $rose(cfg_valid) |-> cfg_data == QUERY_PEER_CMD; endproperty
	a_cmd: assert property (p_cmd) else $error("query code");
	property p_id; cfg_valid && cfg_data != QUERY_PEER_CMD |-> cfg_data <= 8'h1F; endproperty
	a_id: assert property (p_id) else $error("id range");
	property p_ans; $rose(ans_ready) |-> cfg_valid; endproperty
	a_ans: assert property (p_ans) else $error("answer early");
	property p_req; take && busy == 1'b0 && chain_data == ROUTE_REQUEST_TOKEN |=> busy; endproperty
	a_req: assert property (p_req) else $error("request not busy");
	property p_skip;
		take && busy == 1'b0 && chain_data < 8'h10 |-> ##1 !cfg_valid [*4];
	endproperty
	a_skip: assert property (p_skip) else $error("skip queried");
endmodule
`default_nettype wire

// File: verification/erc_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// switch config link
// ---------------
module erc_sw_model
	import erc_pkg::*;
(
	input  wire logic       ref_clk,   // clk
	input  wire logic       rst_n,     // rst
	input  wire logic       cfg_valid, // cmd
	input  wire logic [7:0] cfg_data,  // cmd
	output logic            cfg_ready, // take
	output logic            ans_valid, // answer
	output logic      [7:0] ans_data,  // answer
	input  wire logic       ans_ready  // taken
);
	logic [2:0] cnt;
	logic       got_cmd;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 3'h0; cfg_ready <= 1'b0; ans_valid <= 1'b0;
			ans_data <= 8'hA5; got_cmd <= 1'b0;
		end else begin
			cnt <= cnt + 3'h1;
			cfg_ready <= cnt[0] | cnt[2]; // stalls
			if (cfg_valid && cfg_ready) begin
				got_cmd <= !got_cmd && cfg_data == QUERY_PEER_CMD;
				if (got_cmd) begin
					ans_valid <= 1'b1;
					ans_data <= {cfg_data[0], 2'h0, cfg_data[4:0] ^ 5'h15};
				end
			end
			if (ans_valid && ans_ready) begin
				ans_valid <= 1'b0;
				ans_data <= ~ans_data;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/exchange_route_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// bench
// ---------------
module exchange_route_controller_tb
	import erc_pkg::*;
;
	logic       ref_clk, rst_n, chain_valid, chain_ready, up_valid, up_ready;
	logic       cfg_valid, cfg_ready, ans_valid, ans_ready, busy;
	logic [7:0] chain_data, up_data, cfg_data, ans_data, a, b, c, d;
	logic [7:0] expq[$], cfgq[$];
	integer     seed = 87336;
	int         miscompares = 0, tests_run = 0, cycles = 0, i, k;
	exchange_route_controller u_exchange_route_controller (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.chain_valid (chain_valid),
		.chain_data  (chain_data),
		.chain_ready (chain_ready),
		.up_valid    (up_valid),
		.up_data     (up_data),
		.up_ready    (up_ready),
		.cfg_valid   (cfg_valid),
		.cfg_data    (cfg_data),
		.cfg_ready   (cfg_ready),
		.ans_valid   (ans_valid),
		.ans_data    (ans_data),
		.ans_ready   (ans_ready),
		.busy        (busy)
	);
	erc_sw_model u_erc_sw_model (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.cfg_valid (cfg_valid),
		.cfg_data  (cfg_data),
		.cfg_ready (cfg_ready),
		.ans_valid (ans_valid),
		.ans_data  (ans_data),
		.ans_ready (ans_ready)
	);
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task send(input logic [7:0] v);
		@(negedge ref_clk);
		chain_valid = 1;
		chain_data = v;
		do @(posedge ref_clk); while (!chain_ready);
	endtask
	function automatic logic [7:0] peer(input logic [7:0] n);
		return n[0] ? NIL_NODE : {3'h0, n[4:0] ^ 5'h15};
	endfunction
	always @(negedge ref_clk) up_ready <= rst_n ? 1'($random(seed)) : 1'b0;
	always @(posedge ref_clk) begin
		cycles++;
		if (up_valid && up_ready) check(up_data, expq.size() ? expq.pop_front() : 8'hXX);
		if (cfg_valid && cfg_ready) check(cfg_data, cfgq.size() ? cfgq.pop_front() : 8'hXX);
		if (cycles == 30000) begin
			miscompares++;
			summarize;
		end
	end
	initial begin
		rst_n = 0; chain_valid = 0; chain_data = 8'h00;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1;
		for (i = 0; i < 30; i++) begin
			a = $random(seed) & 8'h1F; b = $random(seed) & 8'h1F;
			c = $random(seed); d = $random(seed);
			k = i % 3;
			if (k == 0) begin
				cfgq = {cfgq, QUERY_PEER_CMD, a, QUERY_PEER_CMD, b};
				expq = {expq, RELEASE_TOKEN, peer(a), peer(b), a, b};
				send(ROUTE_REQUEST_TOKEN);
			end else if (k == 1) begin
				send(i[2] ? ROUTE_ACK_TOKEN : c & 8'h0F);
			end else begin
				expq = {expq, RELEASE_TOKEN, c, d, a, b};
				send(RELEASE_TOKEN);
				send(c);
				send(d);
			end
			send(a);
			send(b);
			@(negedge ref_clk) chain_valid = 0;
			chain_data = ~chain_data;
		end
		for (k = 0; k < 500 && (expq.size() || busy !== 1'b0); k++) @(posedge ref_clk);
		check({7'h0, busy}, 8'h00);
		check(8'(expq.size() + cfgq.size()), 8'h00);
		summarize;
	end
endmodule
bind exchange_route_controller erc_ctl_chk u_erc_ctl_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.chain_valid(chain_valid), .chain_data(chain_data), .chain_ready(chain_ready),
	.up_valid(up_valid), .up_data(up_data), .up_ready(up_ready), .cfg_valid(cfg_valid),
	.cfg_data(cfg_data), .cfg_ready(cfg_ready), .ans_valid(ans_valid), .ans_data(ans_data),
	.ans_ready(ans_ready), .busy(busy));
`default_nettype wire
